// >>> design/cpu_regs_pkg.sv
// Shared constants, operand sizes and carrier types for the register set.
`default_nettype none
package cpu_regs_pkg;

   localparam int DATA_W = 32;
   localparam int PTR_W  = 24;
   localparam int UDP_W  = 16;
   localparam int GPR_N  = 8;
   localparam int ADDR_W = 5;

   // Register port offsets.
   localparam logic [ADDR_W-1:0] REG_GPR0    = 5'h00;
   localparam logic [ADDR_W-1:0] REG_GPR7    = 5'h07;
   localparam logic [ADDR_W-1:0] REG_PC      = 5'h08;
   localparam logic [ADDR_W-1:0] REG_ISP     = 5'h09;
   localparam logic [ADDR_W-1:0] REG_USP     = 5'h0A;
   localparam logic [ADDR_W-1:0] REG_FP      = 5'h0B;
   localparam logic [ADDR_W-1:0] REG_SB      = 5'h0C;
   localparam logic [ADDR_W-1:0] REG_DTB     = 5'h0D;
   localparam logic [ADDR_W-1:0] REG_UDP     = 5'h0E;
   localparam logic [ADDR_W-1:0] REG_PSW_LO  = 5'h0F;
   localparam logic [ADDR_W-1:0] REG_PSW_HI  = 5'h10;

   // Field positions inside the 16-bit status word.
   localparam int PSW_C = 0;
   localparam int PSW_T = 1;
   localparam int PSW_L = 2;
   localparam int PSW_F = 5;
   localparam int PSW_Z = 6;
   localparam int PSW_N = 7;
   localparam int PSW_U = 8;
   localparam int PSW_S = 9;
   localparam int PSW_P = 10;
   localparam int PSW_I = 11;

   // Reset values.
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
   localparam logic [7:0]        HALF_RESET = 8'h00;

   // Operand lengths in bytes, at the pointer width they are added to.
   localparam logic [PTR_W-1:0] LEN_BYTE  = 24'h000001;
   localparam logic [PTR_W-1:0] LEN_WORD  = 24'h000002;
   localparam logic [PTR_W-1:0] LEN_DWORD = 24'h000004;

   typedef enum logic [1:0] {
      OPSZ_BYTE  = 2'h0,
      OPSZ_WORD  = 2'h1,
      OPSZ_DWORD = 2'h2
   } op_size_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      op_size_t          size;
   } reg_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              refused;
   } reg_rsp_t;

endpackage
`default_nettype wire

// >>> design/operand_merge.sv
// Merges a byte, word or double-word operand into the low part of a wider value.
`timescale 1ns/1ps
`default_nettype none
module operand_merge (
   input  wire logic [cpu_regs_pkg::DATA_W-1:0] base,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0] operand,
   input  wire cpu_regs_pkg::op_size_t          size,
   output logic      [cpu_regs_pkg::DATA_W-1:0] merged
);
   import cpu_regs_pkg::*;

   always_comb begin
      unique case (size)
         OPSZ_BYTE:  merged = {base[DATA_W-1:8], operand[7:0]};
         OPSZ_WORD:  merged = {base[DATA_W-1:16], operand[15:0]};
         OPSZ_DWORD: merged = operand;
         default:    merged = operand;
      endcase
   end

endmodule
`default_nettype wire

// >>> design/pointer_reg.sv
// Narrow dedicated register that stores only its significant bits and reads zero above them.
`timescale 1ns/1ps
`default_nettype none
module pointer_reg #(
   parameter int W = 24
) (
   input  wire logic                              core_clk,
   input  wire logic                              rst_n,
   input  wire logic                              load,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0]   din,
   output logic      [cpu_regs_pkg::DATA_W-1:0]   q
);
   import cpu_regs_pkg::*;

   logic [W-1:0] held;

   if (W < 1 || W > DATA_W) begin : g_bad_width
      $error("pointer_reg width out of range");
   end

   // Upper data bits are dropped on the way in, so the stored value can never disagree.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         held <= '0;
      end else if (load) begin
         held <= din[W-1:0];
      end
   end

   assign q = DATA_W'(held);

endmodule
`default_nettype wire

// >>> design/cpu_programming_model_regs.sv
// Architectural register set: general registers, pointers, status word and stack arithmetic.
//
// Behaviour
// - Eight 32-bit general registers.
// - Narrow operands touch only low bits.
// - Program counter holds current instruction address.
// - Pointer registers read upper byte zero.
// - Pointers carry 24 significant address bits.
// - Stack select picks interrupt or user pointer.
// - Stacks grow down; pointer at lowest byte.
// - Push pre-decrements by operand length.
// - Pop reads first, then post-increments.
// - Frame pointer loaded on entry, restored exit.
// - Frame pointer addresses saved old value.
// - Static base holds module globals' address.
// - Dispatch base holds trap table address.
// - Unit descriptor pointer is 16 bits.
// - Status word: two 8-bit independently accessed halves.
// - High status half refused in user mode.
// - Trap or interrupt clears stack select.
// - User bit set refuses privileged access.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cpu_programming_model_regs (
   input  wire logic                            core_clk,
   input  wire logic                            rst_n,
   // Register port from the execution unit.
   input  wire cpu_regs_pkg::reg_req_t          reg_req,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output cpu_regs_pkg::reg_rsp_t               reg_rsp,
   // Instruction sequencing.
   input  wire logic                            pc_load,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0] pc_value,
   // Stack operations on the active stack.
   input  wire logic                            stk_push,
   input  wire logic                            stk_pop,
   input  wire cpu_regs_pkg::op_size_t          stk_size,
   output logic      [cpu_regs_pkg::DATA_W-1:0] stk_addr,
   // Procedure entry and exit.
   input  wire logic                            frame_enter,
   input  wire logic                            frame_exit,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0] frame_restore,
   // Exception entry.
   input  wire logic                            trap_take,
   // State seen by the rest of the core.
   output logic      [cpu_regs_pkg::DATA_W-1:0] program_counter,
   output logic      [cpu_regs_pkg::DATA_W-1:0] active_stack_pointer,
   output logic      [cpu_regs_pkg::DATA_W-1:0] frame_pointer,
   output logic      [cpu_regs_pkg::DATA_W-1:0] static_base,
   output logic      [cpu_regs_pkg::DATA_W-1:0] dispatch_table_base,
   output logic      [cpu_regs_pkg::DATA_W-1:0] unit_descriptor_pointer,
   output logic      [15:0]                     processor_status_word,
   output logic                                 user_mode
);
   import cpu_regs_pkg::*;

   logic [DATA_W-1:0] gpr [GPR_N];
   logic [DATA_W-1:0] interrupt_stack_pointer;
   logic [DATA_W-1:0] user_stack_pointer;
   logic [7:0]        psw_lo;
   logic [7:0]        psw_hi;

   logic              stack_select;
   logic              gpr_hit;
   logic [2:0]        gpr_index;
   logic [DATA_W-1:0] gpr_selected;
   logic [DATA_W-1:0] gpr_written;
   logic [DATA_W-1:0] gpr_read_view;

   logic              push_any;
   logic [PTR_W-1:0]  push_len;
   logic [PTR_W-1:0]  pop_len;
   logic [PTR_W-1:0]  sp_pushed;
   logic [PTR_W-1:0]  sp_popped;
   logic              sp_move;
   logic [DATA_W-1:0] next_sp;

   logic              wr_pc;
   logic              wr_isp;
   logic              wr_usp;
   logic              wr_fp;
   logic              wr_sb;
   logic              wr_dtb;
   logic              wr_udp;
   logic              hi_refused;

   logic              load_pc;
   logic              load_isp;
   logic              load_usp;
   logic              load_fp;
   logic [DATA_W-1:0] next_pc;
   logic [DATA_W-1:0] next_fp;
   logic [DATA_W-1:0] read_value;

   // ---------------------------------------------------------------
   // Privilege and stack selection.
   // ---------------------------------------------------------------
   assign user_mode             = psw_hi[PSW_U-8];
   assign stack_select          = psw_hi[PSW_S-8];
   assign processor_status_word = {psw_hi, psw_lo};

   always_comb begin
      if (stack_select) begin
         active_stack_pointer = user_stack_pointer;
      end else begin
         active_stack_pointer = interrupt_stack_pointer;
      end
   end

   // ---------------------------------------------------------------
   // Write decode.
   // ---------------------------------------------------------------
   assign wr_pc  = reg_wr && (reg_req.addr == REG_PC);
   assign wr_isp = reg_wr && (reg_req.addr == REG_ISP);
   assign wr_usp = reg_wr && (reg_req.addr == REG_USP);
   assign wr_fp  = reg_wr && (reg_req.addr == REG_FP);
   assign wr_sb  = reg_wr && (reg_req.addr == REG_SB);
   assign wr_dtb = reg_wr && (reg_req.addr == REG_DTB);
   assign wr_udp = reg_wr && (reg_req.addr == REG_UDP);

   // A user-mode program must not reach the half that holds its own privilege bit.
   assign hi_refused = (reg_wr || reg_rd) && (reg_req.addr == REG_PSW_HI)
                       && user_mode;

   // ---------------------------------------------------------------
   // Stack arithmetic on the active pointer, 24 bits wide with wrap.
   // ---------------------------------------------------------------
   function automatic logic [PTR_W-1:0] size_len(input op_size_t s);
      unique case (s)
         OPSZ_BYTE:  size_len = LEN_BYTE;
         OPSZ_WORD:  size_len = LEN_WORD;
         OPSZ_DWORD: size_len = LEN_DWORD;
         default:    size_len = LEN_DWORD;
      endcase
   endfunction

   // Entry saves the old frame pointer as a double word, so it is a push of four bytes.
   assign push_any  = stk_push || frame_enter;
   assign push_len  = frame_enter ? LEN_DWORD : size_len(stk_size);
   assign pop_len   = size_len(stk_size);
   assign sp_pushed = active_stack_pointer[PTR_W-1:0] - push_len;
   assign sp_popped = active_stack_pointer[PTR_W-1:0] + pop_len;
   assign sp_move   = push_any || stk_pop;

   always_comb begin
      if (push_any) begin
         next_sp = DATA_W'(sp_pushed);
      end else begin
         next_sp = DATA_W'(sp_popped);
      end
   end

   // The stack operation outranks a software write to the same pointer in one cycle.
   always_comb begin
      load_isp = (sp_move && !stack_select) || wr_isp;
      load_usp = (sp_move && stack_select) || wr_usp;
   end

   // Memory address for the operand: new top on a push, old top on a pop.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stk_addr <= WORD_RESET;
      end else if (push_any) begin
         stk_addr <= DATA_W'(sp_pushed);
      end else if (stk_pop) begin
         stk_addr <= DATA_W'(active_stack_pointer[PTR_W-1:0]);
      end
   end

   pointer_reg #(
      .W (PTR_W)
   ) u_isp (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (load_isp),
      .din      (sp_move && !stack_select ? next_sp : reg_req.wdata),
      .q        (interrupt_stack_pointer)
   );

   pointer_reg #(
      .W (PTR_W)
   ) u_usp (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (load_usp),
      .din      (sp_move && stack_select ? next_sp : reg_req.wdata),
      .q        (user_stack_pointer)
   );

   // ---------------------------------------------------------------
   // Program counter: sequencing wins over a software write.
   // ---------------------------------------------------------------
   assign load_pc = pc_load || wr_pc;
   assign next_pc = pc_load ? pc_value : reg_req.wdata;

   pointer_reg #(
      .W (PTR_W)
   ) u_pc (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (load_pc),
      .din      (next_pc),
      .q        (program_counter)
   );

   // ---------------------------------------------------------------
   // Frame pointer: entry points it at the slot holding the old value.
   // ---------------------------------------------------------------
   assign load_fp = frame_enter || frame_exit || wr_fp;

   always_comb begin
      if (frame_enter) begin
         next_fp = DATA_W'(sp_pushed);
      end else if (frame_exit) begin
         next_fp = frame_restore;
      end else begin
         next_fp = reg_req.wdata;
      end
   end

   pointer_reg #(
      .W (PTR_W)
   ) u_fp (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (load_fp),
      .din      (next_fp),
      .q        (frame_pointer)
   );

   pointer_reg #(
      .W (PTR_W)
   ) u_sb (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (wr_sb),
      .din      (reg_req.wdata),
      .q        (static_base)
   );

   pointer_reg #(
      .W (PTR_W)
   ) u_dtb (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (wr_dtb),
      .din      (reg_req.wdata),
      .q        (dispatch_table_base)
   );

   // Descriptors must sit in the first 64 KiB because only 16 bits are kept.
   pointer_reg #(
      .W (UDP_W)
   ) u_udp (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (wr_udp),
      .din      (reg_req.wdata),
      .q        (unit_descriptor_pointer)
   );

   // ---------------------------------------------------------------
   // General registers with partial-width access.
   // ---------------------------------------------------------------
   assign gpr_hit      = (reg_req.addr <= REG_GPR7);
   assign gpr_index    = reg_req.addr[2:0];
   assign gpr_selected = gpr[gpr_index];

   operand_merge u_wr_merge (
      .base    (gpr_selected),
      .operand (reg_req.wdata),
      .size    (reg_req.size),
      .merged  (gpr_written)
   );

   operand_merge u_rd_merge (
      .base    (WORD_RESET),
      .operand (gpr_selected),
      .size    (reg_req.size),
      .merged  (gpr_read_view)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < GPR_N; i++) begin
            gpr[i] <= WORD_RESET;
         end
      end else if (reg_wr && gpr_hit) begin
         gpr[gpr_index] <= gpr_written;
      end
   end

   // ---------------------------------------------------------------
   // Status word halves.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         psw_lo <= HALF_RESET;
      end else if (reg_wr && (reg_req.addr == REG_PSW_LO)) begin
         psw_lo <= reg_req.wdata[7:0];
      end
   end

   // Exception entry is applied after a same-cycle write so the interrupt stack is certain.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         psw_hi <= HALF_RESET;
      end else begin
         if (reg_wr && (reg_req.addr == REG_PSW_HI) && !user_mode) begin
            psw_hi <= reg_req.wdata[7:0];
         end
         if (trap_take) begin
            psw_hi[PSW_S-8] <= 1'b0;
            if (reg_wr && (reg_req.addr == REG_PSW_HI) && !user_mode) begin
               psw_hi <= {reg_req.wdata[7:PSW_S-7], 1'b0, reg_req.wdata[PSW_S-9:0]};
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path: answer in the following cycle only.
   // ---------------------------------------------------------------
   always_comb begin
      read_value = WORD_RESET;
      if (gpr_hit) begin
         read_value = gpr_read_view;
      end else begin
         unique case (reg_req.addr)
            REG_PC:     read_value = program_counter;
            REG_ISP:    read_value = interrupt_stack_pointer;
            REG_USP:    read_value = user_stack_pointer;
            REG_FP:     read_value = frame_pointer;
            REG_SB:     read_value = static_base;
            REG_DTB:    read_value = dispatch_table_base;
            REG_UDP:    read_value = unit_descriptor_pointer;
            REG_PSW_LO: read_value = DATA_W'(psw_lo);
            REG_PSW_HI: read_value = user_mode ? WORD_RESET : DATA_W'(psw_hi);
            default:    read_value = WORD_RESET;
         endcase
      end
   end

   // One process owns the whole response, so the struct has a single driver.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rsp <= '{data: WORD_RESET, refused: 1'b0};
      end else begin
         reg_rsp.data    <= reg_rd ? read_value : WORD_RESET;
         reg_rsp.refused <= hi_refused;
      end
   end

endmodule
`default_nettype wire

// >>> test/regs_monitor.sv
// Port-level assertions for the architectural register set.
`timescale 1ns/1ps
`default_nettype none
module regs_monitor
   import cpu_regs_pkg::*;
(
   input wire logic                     core_clk,
   input wire logic                     rst_n,
   input wire cpu_regs_pkg::reg_req_t   reg_req,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire cpu_regs_pkg::reg_rsp_t   reg_rsp,
   input wire logic                     pc_load,
   input wire logic [31:0]              pc_value,
   input wire logic                     stk_push,
   input wire logic                     stk_pop,
   input wire cpu_regs_pkg::op_size_t   stk_size,
   input wire logic [31:0]              stk_addr,
   input wire logic                     frame_enter,
   input wire logic                     frame_exit,
   input wire logic [31:0]              frame_restore,
   input wire logic                     trap_take,
   input wire logic [31:0]              program_counter,
   input wire logic [31:0]              active_stack_pointer,
   input wire logic [31:0]              frame_pointer,
   input wire logic [31:0]              static_base,
   input wire logic [31:0]              dispatch_table_base,
   input wire logic [31:0]              unit_descriptor_pointer,
   input wire logic [15:0]              processor_status_word,
   input wire logic                     user_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // A trap or software write in the same cycle may swap or reload the stack pointer.
   logic quiet;
   assign quiet = !trap_take && !reg_wr;

   function automatic logic [23:0] blen(input op_size_t s);
      return (s == OPSZ_BYTE) ? LEN_BYTE : ((s == OPSZ_WORD) ? LEN_WORD : LEN_DWORD);
   endfunction

   chk_push_pre_dec: assert property (
      stk_push && !frame_enter && quiet |=> stk_addr == active_stack_pointer &&
      stk_addr == {8'h00, $past(active_stack_pointer[23:0]) - blen($past(stk_size))})
      else $error("push did not pre-decrement the stack pointer");
   chk_pop_post_inc: assert property (
      stk_pop && !stk_push && !frame_enter && quiet |=> stk_addr == $past(active_stack_pointer)
      && active_stack_pointer == {8'h00, $past(active_stack_pointer[23:0]) + blen($past(stk_size))})
      else $error("pop did not post-increment the stack pointer");
   chk_enter_frame: assert property (
      frame_enter && !stk_push && !stk_pop && quiet |=> frame_pointer == stk_addr &&
      stk_addr == {8'h00, $past(active_stack_pointer[23:0]) - LEN_DWORD})
      else $error("enter did not point the frame at the saved value");
   chk_exit_frame: assert property (
      frame_exit && !frame_enter |=> frame_pointer == {8'h00, $past(frame_restore[23:0])})
      else $error("exit did not restore the frame pointer");
   chk_trap_stack: assert property (
      trap_take |=> !processor_status_word[PSW_S])
      else $error("trap left the user stack selected");
   chk_hi_rd_refused: assert property (
      reg_rd && reg_req.addr == REG_PSW_HI && user_mode |=>
      reg_rsp.refused && reg_rsp.data == 32'h0000_0000)
      else $error("user read of high status half not refused");
   chk_hi_wr_refused: assert property (
      reg_wr && reg_req.addr == REG_PSW_HI && user_mode && !trap_take |=>
      reg_rsp.refused && $stable(processor_status_word[15:8]))
      else $error("user write of high status half not refused");
   chk_sup_allowed: assert property (
      (reg_rd || reg_wr) && !user_mode |=> !reg_rsp.refused)
      else $error("supervisor access refused");
   chk_rsp_idle: assert property (
      !reg_rd |=> reg_rsp.data == 32'h0000_0000)
      else $error("read data present without a read");
   chk_ptr_width: assert property (
      (program_counter | active_stack_pointer | frame_pointer | static_base |
       dispatch_table_base) < 32'h0100_0000 && unit_descriptor_pointer < 32'h0001_0000)
      else $error("pointer upper bits not zero");
   chk_mode_bit: assert property (
      user_mode == processor_status_word[PSW_U])
      else $error("user mode output differs from status bit");
   chk_pc_load: assert property (
      pc_load |=> program_counter == {8'h00, $past(pc_value[23:0])})
      else $error("program counter load wrong");
endmodule

bind cpu_programming_model_regs regs_monitor i_mon (
   .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rsp(reg_rsp), .pc_load(pc_load), .pc_value(pc_value), .stk_push(stk_push),
   .stk_pop(stk_pop), .stk_size(stk_size), .stk_addr(stk_addr), .frame_enter(frame_enter),
   .frame_exit(frame_exit), .frame_restore(frame_restore), .trap_take(trap_take),
   .program_counter(program_counter), .active_stack_pointer(active_stack_pointer),
   .frame_pointer(frame_pointer), .static_base(static_base),
   .dispatch_table_base(dispatch_table_base), .unit_descriptor_pointer(unit_descriptor_pointer),
   .processor_status_word(processor_status_word), .user_mode(user_mode));
`default_nettype wire

// >>> test/cpu_programming_model_regs_bench.sv
// Self-checking bench for the architectural register set.
`timescale 1ns/1ps
`default_nettype none
module cpu_programming_model_regs_bench;
   import cpu_regs_pkg::*;

   typedef struct packed {
      logic [4:0]  a;
      op_size_t    ws;
      logic [31:0] d;
      op_size_t    rs;
      logic [31:0] e;
   } row_t;

   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   reg_req_t    reg_req = '0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, pc_load = 1'b0, stk_push = 1'b0, stk_pop = 1'b0;
   logic        frame_enter = 1'b0, frame_exit = 1'b0, trap_take = 1'b0;
   logic [31:0] pc_value = '0, frame_restore = '0;
   op_size_t    stk_size = OPSZ_BYTE;
   reg_rsp_t    reg_rsp;
   logic [31:0] stk_addr, program_counter, active_stack_pointer, frame_pointer;
   logic [31:0] static_base, dispatch_table_base, unit_descriptor_pointer;
   logic [15:0] processor_status_word;
   logic        user_mode;
   int          n_fail = 0;
   int          n_checks = 0;
   row_t        rows [14] = '{
      '{REG_GPR0, OPSZ_DWORD, 32'h89AB_CDEF, OPSZ_DWORD, 32'h89AB_CDEF},
      '{REG_GPR7, OPSZ_DWORD, 32'h1234_5678, OPSZ_DWORD, 32'h1234_5678},
      '{REG_GPR0, OPSZ_BYTE, 32'hFFFF_FF11, OPSZ_DWORD, 32'h89AB_CD11},
      '{REG_GPR0, OPSZ_WORD, 32'h0000_2233, OPSZ_DWORD, 32'h89AB_2233},
      '{REG_GPR7, OPSZ_WORD, 32'h0000_AAAA, OPSZ_BYTE, 32'h0000_00AA},
      '{REG_PC, OPSZ_DWORD, 32'hFFAB_CDEF, OPSZ_DWORD, 32'h00AB_CDEF},
      '{REG_ISP, OPSZ_DWORD, 32'hFF00_0100, OPSZ_DWORD, 32'h0000_0100},
      '{REG_USP, OPSZ_DWORD, 32'h0000_0200, OPSZ_DWORD, 32'h0000_0200},
      '{REG_FP, OPSZ_DWORD, 32'hFFFF_FFFF, OPSZ_DWORD, 32'h00FF_FFFF},
      '{REG_SB, OPSZ_DWORD, 32'hFFFF_FFFF, OPSZ_DWORD, 32'h00FF_FFFF},
      '{REG_DTB, OPSZ_DWORD, 32'hAB12_3456, OPSZ_DWORD, 32'h0012_3456},
      '{REG_UDP, OPSZ_DWORD, 32'hFFFF_1234, OPSZ_DWORD, 32'h0000_1234},
      '{REG_PSW_LO, OPSZ_DWORD, 32'h0000_03A5, OPSZ_DWORD, 32'h0000_00A5},
      '{5'h1F, OPSZ_DWORD, 32'hFFFF_FFFF, OPSZ_DWORD, 32'h0000_0000}};

   cpu_programming_model_regs i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rsp(reg_rsp), .pc_load(pc_load), .pc_value(pc_value),
      .stk_push(stk_push), .stk_pop(stk_pop), .stk_size(stk_size), .stk_addr(stk_addr),
      .frame_enter(frame_enter), .frame_exit(frame_exit), .frame_restore(frame_restore),
      .trap_take(trap_take), .program_counter(program_counter),
      .active_stack_pointer(active_stack_pointer), .frame_pointer(frame_pointer),
      .static_base(static_base), .dispatch_table_base(dispatch_table_base),
      .unit_descriptor_pointer(unit_descriptor_pointer),
      .processor_status_word(processor_status_word), .user_mode(user_mode));

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   // Every pulse input drops at the edge that takes it, so outputs are sampled settled.
   task automatic step;
      @(posedge core_clk);
      {reg_wr, reg_rd, pc_load, stk_push, stk_pop, frame_enter, frame_exit, trap_take} <= '0;
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input op_size_t s);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_req <= '{a, d, s};
      step;
   endtask

   task automatic rd(input logic [4:0] a, input op_size_t s);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_req <= '{a, 32'h0000_0000, s};
      step;
   endtask

   task automatic stk(input logic p, input logic q, input logic e, input op_size_t s);
      @(posedge core_clk);
      stk_push <= p;
      stk_pop <= q;
      frame_enter <= e;
      stk_size <= s;
      step;
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #100us;
      n_fail++;
      conclude;
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check(active_stack_pointer, 32'h0000_0000);
      check({16'h0000, processor_status_word}, 32'h0000_0000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].ws);
         rd(rows[i].a, rows[i].rs);
         check(reg_rsp.data, rows[i].e);
      end
      check(program_counter, 32'h00AB_CDEF);
      check(static_base, 32'h00FF_FFFF);
      check(dispatch_table_base, 32'h0012_3456);
      check(unit_descriptor_pointer, 32'h0000_1234);
      stk(1'b1, 1'b0, 1'b0, OPSZ_DWORD);
      check(active_stack_pointer, 32'h0000_00FC);
      stk(1'b0, 1'b1, 1'b0, OPSZ_WORD);
      check(stk_addr, 32'h0000_00FC);
      check(active_stack_pointer, 32'h0000_00FE);
      stk(1'b1, 1'b1, 1'b0, OPSZ_BYTE);
      check(active_stack_pointer, 32'h0000_00FD);
      stk(1'b0, 1'b0, 1'b1, OPSZ_BYTE);
      check(frame_pointer, 32'h0000_00F9);
      check(stk_addr, 32'h0000_00F9);
      @(posedge core_clk);
      frame_exit <= 1'b1;
      frame_restore <= 32'hFF00_0040;
      step;
      check(frame_pointer, 32'h0000_0040);
      wr(REG_ISP, 32'h0000_0000, OPSZ_DWORD);
      stk(1'b1, 1'b0, 1'b0, OPSZ_BYTE);
      check(active_stack_pointer, 32'h00FF_FFFF);
      stk(1'b0, 1'b1, 1'b0, OPSZ_BYTE);
      check(active_stack_pointer, 32'h0000_0000);
      wr(REG_PSW_HI, 32'h0000_0002, OPSZ_BYTE);
      check(active_stack_pointer, 32'h0000_0200);
      stk(1'b1, 1'b0, 1'b0, OPSZ_WORD);
      rd(REG_USP, OPSZ_DWORD);
      check(reg_rsp.data, 32'h0000_01FE);
      rd(REG_ISP, OPSZ_DWORD);
      check(reg_rsp.data, 32'h0000_0000);
      @(posedge core_clk);
      trap_take <= 1'b1;
      step;
      check(active_stack_pointer, 32'h0000_0000);
      @(posedge core_clk);
      pc_load <= 1'b1;
      pc_value <= 32'hFFFF_FFFE;
      step;
      check(program_counter, 32'h00FF_FFFE);
      wr(REG_PSW_HI, 32'h0000_0001, OPSZ_BYTE);
      check({31'h0, user_mode}, 32'h0000_0001);
      rd(REG_PSW_HI, OPSZ_BYTE);
      check({reg_rsp.data[30:0], reg_rsp.refused}, 32'h0000_0001);
      wr(REG_PSW_HI, 32'h0000_0000, OPSZ_BYTE);
      check({31'h0, reg_rsp.refused}, 32'h0000_0001);
      rd(REG_PSW_LO, OPSZ_BYTE);
      check({reg_rsp.data[30:0], reg_rsp.refused}, 32'h0000_014A);
      check({16'h0000, processor_status_word}, 32'h0000_01A5);
      @(posedge core_clk);
      rst_n <= 1'b0;
      step;
      check({15'h0, user_mode, processor_status_word}, 32'h0000_0000);
      @(posedge core_clk);
      rst_n <= 1'b1;
      wr(REG_GPR7, 32'hFFFF_FF55, OPSZ_BYTE);
      rd(REG_GPR7, OPSZ_DWORD);
      check(reg_rsp.data, 32'h0000_0055);
      conclude;
   end
endmodule
`default_nettype wire
